// ===== hdl/scpc_defines.svh
`ifndef SCPC_DEFINES_SVH
`define SCPC_DEFINES_SVH

// Port configuration register and its fields.
`define SCPC_CFG_ADDR 5'h00
`define SCPC_CFG_3WIRE_BIT 7
`define SCPC_CFG_LSB_BIT 6

// Reset value of every configuration register.
`define SCPC_REG_RESET 8'h00

// Instruction byte fields.
`define SCPC_INS_RW_BIT 7
`define SCPC_INS_CNT_HI 6
`define SCPC_INS_CNT_LO 5
`define SCPC_INS_ADDR_HI 4

// Bit counter value of the last bit in a byte.
`define SCPC_LAST_BIT 3'h7

`endif

// ===== hdl/scpc_pkg.sv
package scpc_pkg;

  typedef enum logic [2:0] {
    SCPC_INSTR = 3'b001,
    SCPC_DATA  = 3'b010,
    SCPC_DONE  = 3'b100
  } scpc_phase_e;

  // Protocol state, restarted by every chip select.
  typedef struct packed {
    scpc_phase_e phase;
    logic [2:0] bit_cnt;
    logic [7:0] shift;
    logic is_read;
    logic [1:0] bytes_left;
    logic [4:0] addr;
  } scpc_proto_s;

  // Register file and write notice, kept across chip selects.
  typedef struct packed {
    logic [31:0][7:0] mem;
    logic wr_tog;
    logic [4:0] wr_addr;
    logic [7:0] wr_data;
  } scpc_regs_s;

  // Serial output pins, updated on the falling serial clock edge.
  typedef struct packed {
    logic line;
    logic line_oe;
    logic serial_data_out;
    logic sdo_oe;
  } scpc_pins_s;

  // System clock side.
  typedef struct packed {
    logic [2:0] tog_sync;
    logic [1:0] wire_sync;
    logic [1:0] lsb_sync;
    logic wr_strobe;
    logic [4:0] wr_addr;
    logic [7:0] wr_data;
  } scpc_core_s;

endpackage

// ===== hdl/scpc_top.sv
`timescale 1ns/1ps
`include "scpc_defines.svh"

module scpc_top (
  // System clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // Serial link
  input wire logic serial_clk_i,
  input wire logic chip_select_n_i,
  input wire logic data_line_i,
  output logic data_line_o,
  output logic data_line_oe_o,
  output logic serial_data_out_o,
  output logic serial_data_out_oe_o,
  // Register write notices and port configuration, system clock side
  output logic wr_strobe_o,
  output logic [4:0] wr_addr_o,
  output logic [7:0] wr_data_o,
  output logic cfg_three_wire_o,
  output logic cfg_lsb_first_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Serial clock domain.

  scpc_pkg::scpc_proto_s proto;
  scpc_pkg::scpc_proto_s next_proto;
  scpc_pkg::scpc_regs_s regs;
  scpc_pkg::scpc_regs_s next_regs;
  scpc_pkg::scpc_pins_s pins;
  scpc_pkg::scpc_pins_s next_pins;
  logic link_rst;
  logic lsb_now;
  logic lsb_next;
  logic [7:0] byte_in;
  logic [7:0] tx_byte;
  logic tx_bit;
  logic driving;

  // A high chip select holds the protocol and the pins in reset.
  // Asynchronous abort
  assign link_rst = sys_rst_i | chip_select_n_i;

  always_comb begin
    next_proto = proto;
    next_regs = regs;
    lsb_now = regs.mem[`SCPC_CFG_ADDR][`SCPC_CFG_LSB_BIT];
    if (lsb_now) begin
      byte_in = {data_line_i, proto.shift[7:1]};
    end else begin
      byte_in = {proto.shift[6:0], data_line_i};
    end
    if (proto.phase != scpc_pkg::SCPC_DONE) begin
      next_proto.shift = byte_in;
      next_proto.bit_cnt = proto.bit_cnt + 3'h1;
    end
    if (proto.bit_cnt == `SCPC_LAST_BIT) begin
      if (proto.phase == scpc_pkg::SCPC_INSTR) begin
        next_proto.is_read = byte_in[`SCPC_INS_RW_BIT];
        next_proto.bytes_left = byte_in[`SCPC_INS_CNT_HI:`SCPC_INS_CNT_LO];
        next_proto.addr = byte_in[`SCPC_INS_ADDR_HI:0];
        next_proto.phase = scpc_pkg::SCPC_DATA;
      end else if (proto.phase == scpc_pkg::SCPC_DATA) begin
        if (!proto.is_read) begin
          next_regs.mem[proto.addr] = byte_in;
          next_regs.wr_tog = ~regs.wr_tog;
          next_regs.wr_addr = proto.addr;
          next_regs.wr_data = byte_in;
        end
        if (proto.bytes_left == 2'h0) begin
          next_proto.phase = scpc_pkg::SCPC_DONE;
        end
        next_proto.bytes_left = proto.bytes_left - 2'h1;
      end
    end
    // The step follows the order just written, so a configuration byte
    // inside a burst already steers the address of the next byte.
    // Configuration acts at once
    lsb_next = next_regs.mem[`SCPC_CFG_ADDR][`SCPC_CFG_LSB_BIT];
    if (proto.bit_cnt == `SCPC_LAST_BIT && proto.phase == scpc_pkg::SCPC_DATA) begin
      if (lsb_next) begin
        next_proto.addr = proto.addr + 5'h01;
      end else begin
        next_proto.addr = proto.addr - 5'h01;
      end
    end
  end

  // Bits not yet complete when the chip select rises are simply dropped.
  always_ff @(posedge serial_clk_i or posedge link_rst) begin
    if (link_rst) begin
      proto <= '{phase: scpc_pkg::SCPC_INSTR, default: '0};
    end else begin
      proto <= next_proto;
    end
  end

  // The register file survives an abort, so only system reset clears it.
  always_ff @(posedge serial_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      regs <= '{mem: {32{`SCPC_REG_RESET}}, default: '0};
    end else begin
      regs <= next_regs;
    end
  end

  always_comb begin
    next_pins = '0;
    tx_byte = regs.mem[proto.addr];
    if (lsb_now) begin
      tx_bit = tx_byte[proto.bit_cnt];
    end else begin
      tx_bit = tx_byte[3'h7 - proto.bit_cnt];
    end
    driving = (proto.phase == scpc_pkg::SCPC_DATA) && proto.is_read;
    if (regs.mem[`SCPC_CFG_ADDR][`SCPC_CFG_3WIRE_BIT]) begin
      next_pins.line = tx_bit;
      next_pins.line_oe = driving;
    end else begin
      next_pins.serial_data_out = tx_bit;
      next_pins.sdo_oe = driving;
    end
  end

  always_ff @(negedge serial_clk_i or posedge link_rst) begin
    if (link_rst) begin
      pins <= '0;
    end else begin
      pins <= next_pins;
    end
  end

  assign data_line_o = pins.line;
  assign data_line_oe_o = pins.line_oe;
  assign serial_data_out_o = pins.serial_data_out;
  assign serial_data_out_oe_o = pins.sdo_oe;

  ////////////////////////////////////////////////////////////////////////////
  // System clock domain.

  scpc_pkg::scpc_core_s core;
  scpc_pkg::scpc_core_s next_core;

  // The written address and data stay put for eight serial clocks after the
  // toggle, far longer than the three system clocks the crossing needs.
  always_comb begin
    next_core = core;
    next_core.tog_sync = {core.tog_sync[1:0], regs.wr_tog};
    next_core.wire_sync = {core.wire_sync[0], regs.mem[`SCPC_CFG_ADDR][`SCPC_CFG_3WIRE_BIT]};
    next_core.lsb_sync = {core.lsb_sync[0], regs.mem[`SCPC_CFG_ADDR][`SCPC_CFG_LSB_BIT]};
    next_core.wr_strobe = core.tog_sync[2] ^ core.tog_sync[1];
    if (core.tog_sync[2] ^ core.tog_sync[1]) begin
      next_core.wr_addr = regs.wr_addr;
      next_core.wr_data = regs.wr_data;
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      core <= '0;
    end else begin
      core <= next_core;
    end
  end

  assign wr_strobe_o = core.wr_strobe;
  assign wr_addr_o = core.wr_addr;
  assign wr_data_o = core.wr_data;
  assign cfg_three_wire_o = core.wire_sync[1];
  assign cfg_lsb_first_o = core.lsb_sync[1];

endmodule

// ===== tb/scpc_checker.sv
`timescale 1ns/1ps
module scpc_checker (
  // Clock, reset and link select
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic chip_select_n_i,
  // Watched outputs
  input wire logic data_line_oe_o,
  input wire logic serial_data_out_oe_o,
  input wire logic wr_strobe_o,
  input wire logic [4:0] wr_addr_o,
  input wire logic [7:0] wr_data_o,
  input wire logic cfg_three_wire_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  // Either serial output pin is being driven.
  wire logic any_oe;
  assign any_oe = data_line_oe_o || serial_data_out_oe_o;
  // Eight system cycles are four serial bits, shorter than any byte.
  sequence s_held(sig);
    sig [*8];
  endsequence
  a_idle_release: assert property (chip_select_n_i |-> !any_oe)
    else $error("output enabled while deselected");
  a_one_pin: assert property (!(data_line_oe_o && serial_data_out_oe_o))
    else $error("both outputs enabled");
  a_line_mode: assert property (data_line_oe_o |-> cfg_three_wire_o)
    else $error("shared line driven in four-wire mode");
  a_sdo_mode: assert property (serial_data_out_oe_o |-> !cfg_three_wire_o)
    else $error("output pin driven in three-wire mode");
  a_instr_quiet: assert property ($fell(chip_select_n_i) |-> s_held(!any_oe))
    else $error("output enabled during instruction");
  a_byte_hold: assert property ($rose(any_oe) |-> s_held(any_oe))
    else $error("read drive dropped early");
  a_strobe_gap: assert property (wr_strobe_o |=> s_held(!wr_strobe_o))
    else $error("write strobe too long or too close");
  a_wr_hold: assert property (!wr_strobe_o |-> $stable(wr_addr_o) && $stable(wr_data_o))
    else $error("write notice changed without strobe");
endmodule
bind scpc_top scpc_checker chk (.ref_clk_i, .sys_rst_i, .chip_select_n_i, .data_line_oe_o,
  .serial_data_out_oe_o, .wr_strobe_o, .wr_addr_o, .wr_data_o, .cfg_three_wire_o);

// ===== tb/scpc_master.sv
`timescale 1ns/1ps
module scpc_master (
  // Serial lines toward the port
  output logic sclk_o,
  output logic csn_o,
  output logic mosi_o,
  input wire logic miso_i
);
  initial begin
    sclk_o = 1'b0;
    csn_o = 1'b1;
    mosi_o = 1'b0;
  end
  // The clock stands low between frames; a released line toggles so stale bits never match.
  task automatic xfer(input logic lsb, input logic [7:0] ins, input logic [31:0] wd,
                      input int n, input int cut, output logic [31:0] rd);
    logic [7:0] b;
    int p;
    rd = '0;
    #7 csn_o = 1'b0;
    for (int j = 0; j < 8 * n + 8 && j < cut; j++) begin
      b = (j < 8) ? ins : wd[8 * (j / 8 - 1) +: 8];
      p = lsb ? j % 8 : 7 - j % 8;
      if (j < 8 || !ins[7]) mosi_o = b[p];
      else mosi_o = ~mosi_o;
      #40 sclk_o = 1'b1;
      if (j >= 8) rd[8 * (j / 8 - 1) + p] = miso_i;
      #40 sclk_o = 1'b0;
    end
    #40 csn_o = 1'b1;
    mosi_o = ~mosi_o;
    #80;
  endtask
endmodule

// ===== tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  typedef struct packed {
    logic [7:0] cfg;
    logic [4:0] addr;
    logic [1:0] cnt;
    logic [31:0] data;
  } scpc_row_s;
  logic ref_clk_i = 1'b0;
  logic sys_rst_i = 1'b0;
  wire serial_clk_i, chip_select_n_i, mosi, data_line_i;
  logic data_line_o, data_line_oe_o, serial_data_out_o, serial_data_out_oe_o;
  logic wr_strobe_o, cfg_three_wire_o, cfg_lsb_first_o, lsb;
  logic [4:0] wr_addr_o, exp_addr;
  logic [7:0] wr_data_o;
  logic [31:0] rd, mask;
  int bad_count = 0;
  int n_compared = 0;
  int n_wr = 0;
  int e;
  scpc_row_s rows [6] = '{'{8'h00, 5'h0A, 2'h0, 32'h55}, '{8'h00, 5'h05, 2'h3, 32'hA1B2C3D4},
    '{8'h40, 5'h1C, 2'h2, 32'hE7186B}, '{8'h00, 5'h1F, 2'h1, 32'h996E},
    '{8'h80, 5'h10, 2'h1, 32'h3CF0}, '{8'hC0, 5'h08, 2'h3, 32'h5AA5F00F}};
  always #20 ref_clk_i = ~ref_clk_i;
  // The strobe is counted where it has settled, half a cycle after its launch.
  always @(negedge ref_clk_i) if (wr_strobe_o === 1'b1) n_wr++;
  assign data_line_i = data_line_oe_o ? data_line_o : mosi;
  scpc_master m (.sclk_o(serial_clk_i), .csn_o(chip_select_n_i), .mosi_o(mosi),
    .miso_i(serial_data_out_oe_o ? serial_data_out_o : data_line_i));
  scpc_top dut (.ref_clk_i, .sys_rst_i, .serial_clk_i, .chip_select_n_i, .data_line_i,
    .data_line_o, .data_line_oe_o, .serial_data_out_o, .serial_data_out_oe_o, .wr_strobe_o,
    .wr_addr_o, .wr_data_o, .cfg_three_wire_o, .cfg_lsb_first_o);
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    // The reset rises after time zero so that every asynchronous reset sees an edge.
    #1 sys_rst_i = 1'b1;
    lsb = 1'b0;
    repeat (8) @(negedge ref_clk_i);
    sys_rst_i = 1'b0;
    foreach (rows[r]) begin
      e = n_wr;
      m.xfer(lsb, 8'h00, {24'h0, rows[r].cfg}, 1, 99, rd);
      lsb = rows[r].cfg[6];
      m.xfer(lsb, {1'b0, rows[r].cnt, rows[r].addr}, rows[r].data, rows[r].cnt + 1, 99, rd);
      repeat (6) @(negedge ref_clk_i);
      check(32'(cfg_lsb_first_o), 32'(lsb));
      check(32'(cfg_three_wire_o), 32'(rows[r].cfg[7]));
      exp_addr = 5'(lsb ? rows[r].addr + rows[r].cnt : rows[r].addr - rows[r].cnt);
      check(32'(wr_addr_o), 32'(exp_addr));
      check(32'(wr_data_o), 32'(rows[r].data[8 * rows[r].cnt +: 8]));
      check(n_wr - e, rows[r].cnt + 2);
      m.xfer(lsb, {1'b1, rows[r].cnt, rows[r].addr}, 32'h0, rows[r].cnt + 1, 99, rd);
      mask = 32'hFFFFFFFF >> (8 * (3 - rows[r].cnt));
      check(rd & mask, rows[r].data & mask);
      $display("row %0d done", r);
    end
    sys_rst_i = 1'b1;
    repeat (8) @(negedge ref_clk_i);
    sys_rst_i = 1'b0;
    lsb = 1'b0;
    // The configuration outputs lag two cycles, so look after the synchronisers flush.
    repeat (4) @(negedge ref_clk_i);
    check(32'({cfg_three_wire_o, cfg_lsb_first_o}), 32'h0);
    $display("reset test done");
    // A cut in the second data byte must keep only the first one.
    e = n_wr;
    m.xfer(1'b0, 8'h2C, 32'hBEEF, 2, 20, rd);
    check(n_wr - e, 1);
    m.xfer(1'b0, 8'hAC, 32'h0, 2, 99, rd);
    check(rd, 32'hEF);
    $display("abort test done");
    close_out;
  end
  initial begin
    #1000000;
    bad_count++;
    close_out;
  end
endmodule
